// File: verif/ofc_flash_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// behavioural flash device on the far side of the octal link
module ofc_flash_model #(
    parameter logic [63:0] PASS_WORD = 64'h0123_4567_89ab_cdef
) (
    input wire logic flash_ck,
    input wire logic flash_csn,
    input wire logic flash_rstn,
    input wire logic [7:0] dq_o,
    input wire logic dq_oe,
    input wire logic ddr_mode,
    output logic [7:0] dq_i
);
    logic [7:0] rx[$]; // bytes of the current frame
    logic [7:0] last_op, dyn, pers, ecnt, sec, dq_r;
    logic wel, lock, locked, armed, sleep, susp;
    int frames = 0;
    int ob;
    initial begin
        {wel, lock, locked, armed, sleep, susp} = '0;
        {last_op, ecnt, sec, dq_r} = '0;
        dyn = 8'hff;
        pers = 8'hff;
    end
    assign ob = ddr_mode ? 2 : 1;
    // released bus shows the inverse of the last byte, never a stale copy
    assign dq_i = (!flash_csn && !dq_oe && !locked) ? dq_r : ~dq_r;
    // read byte for each read opcode
    function automatic logic [7:0] rd_byte(input logic [7:0] op);
        case (op)
            8'h2d: return {7'h0, lock};
            8'he0: return dyn;
            8'he2: return pers;
            8'h5d: return ecnt;
            8'hd0: return 8'h01;
            8'h4b: return sec;
            default: return 8'h00;
        endcase
    endfunction : rd_byte
    // both ck edges carry a byte in ddr, late edge drives read data in sdr
    always @(flash_ck) begin
        if (!flash_csn && dq_oe && (ddr_mode || flash_ck)) rx.push_back(dq_o);
        if (!flash_csn && !dq_oe && (ddr_mode || !flash_ck)) dq_r = rd_byte(rx[0]);
    end
    always @(negedge flash_csn) rx.delete();
    // only the reset pin leaves the lockup
    always @(negedge flash_rstn) begin
        locked = 0;
        wel = 0;
        dyn = 8'hff;
    end
    // frame decode at chip-select release
    always @(posedge flash_csn) begin
        if (!locked && rx.size() > 0) decode();
    end
    task automatic decode();
        logic [7:0] op;
        logic [63:0] pw;
        logic wc;
        op = rx[0];
        frames++;
        last_op = op;
        wc = op inside {8'h21, 8'hdc, 8'h60, 8'hc7, 8'h42, 8'he1, 8'he3, 8'he4, 8'h2c};
        // write-class frame without the latch is ignored
        if (!wc || wel) begin
            case (op)
                8'h06: wel = 1;
                8'h21, 8'hdc, 8'h60, 8'hc7: ecnt++;
                8'h42: sec = rx[ob+4];
                8'he1: dyn = rx[ob+4];
                8'he3: pers = 8'h00;
                8'he4: pers = 8'hff;
                8'h2c: lock = 0;
                8'he9: begin
                    for (int i = 0; i < 8; i++) pw[8*i+:8] = rx[ob+4+i];
                    if (pw === PASS_WORD) lock = 1;
                    else locked = 1;
                end
                // reset only right after the arm frame
                8'h99: if (armed) begin
                    dyn = 8'hff;
                    wel = 0;
                end
                8'hb0: susp = 1;
                8'h30: susp = 0;
                8'hb9: sleep = 1;
                default: ;
            endcase
            if (wc) wel = 0;
        end
        armed = (op == 8'h66);
    endtask : decode
endmodule : ofc_flash_model

// File: verif/tb_top.sv
`timescale 1ns/10ps
`include "ofc_cfg.svh"
module tb_top;
    localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [31:0] paddr, pwdata, prdata, q;
    logic flash_ck, flash_csn, flash_rstn, dq_oe, ddr_mode;
    logic [7:0] dq_o, dq_i;
    int n_fail, compares;
    int cyc = 0;
    ofc_host dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_ck(flash_ck), .flash_csn(flash_csn),
        .flash_rstn(flash_rstn), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
    ofc_flash_model #(.PASS_WORD(PW)) fm_u (.flash_ck(flash_ck), .flash_csn(flash_csn),
        .flash_rstn(flash_rstn), .dq_o(dq_o), .dq_oe(dq_oe), .ddr_mode(ddr_mode), .dq_i(dq_i));
    always #12.5 pclk = ~pclk;
    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one apb transfer, idle cycle after so strobes never retoggle in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    // set up one frame, start it, wait for done or refusal, clear flags
    task automatic run(input logic [7:0] op, input logic d, input logic [31:0] a,
        input logic [31:0] len, input logic [63:0] tx, output logic [31:0] st);
        int n;
        logic [31:0] z;
        ddr_mode <= d;
        apb(1, `OFC_REG_ADDR, a, z);
        apb(1, `OFC_REG_TXLO, tx[31:0], z);
        apb(1, `OFC_REG_TXHI, tx[63:32], z);
        apb(1, `OFC_REG_LEN, len, z);
        apb(1, `OFC_REG_CTRL, {22'h0, 1'b1, d, op}, z);
        n = 0;
        do begin
            apb(0, `OFC_REG_STAT, 32'h0, st);
            n++;
        end while (st[1] !== 1'b1 && st[2] !== 1'b1 && n < 400);
        if (n == 400) chk("poll", 0, 1);
        apb(1, `OFC_REG_STAT, 32'h6, z);
    endtask : run
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_idle;
        chk("idle pins", {flash_ck, flash_csn, flash_rstn, dq_oe}, 4'b0110);
        apb(0, `OFC_REG_STAT, 32'h0, q);
        chk("stat", q, 32'h0);
        apb(0, 8'h20, 32'h0, q);
        chk("unmapped", {e, q}, {1'b1, 32'h0});
    endtask : t_idle
    task automatic t_erase;
        run(8'h06, 1, 32'h0, 32'h0, 64'h0, q);
        chk("wel", q[`OFC_STAT_WEL], 1);
        run(8'h21, 1, 32'h1234_5678, 32'h0, 64'h0, q);
        chk("op twice", {fm_u.rx[0], fm_u.rx[1]}, 16'h2121);
        chk("addr", {fm_u.rx[2], fm_u.rx[3], fm_u.rx[4], fm_u.rx[5]}, 32'h1234_5678);
        chk("count", fm_u.ecnt, 8'h01);
        chk("wel off", q[`OFC_STAT_WEL], 0);
    endtask : t_erase
    task automatic t_refuse;
        int n;
        n = fm_u.frames;
        run(8'h60, 0, 32'h0, 32'h0, 64'h0, q);
        chk("refused", q[`OFC_STAT_REFUSED], 1);
        chk("no frame", fm_u.frames, n);
    endtask : t_refuse
    task automatic t_ops;
        logic [7:0] ops[9] = '{8'hdc, 8'h60, 8'hc7, 8'he3, 8'he4, 8'h2c, 8'hb0, 8'h30, 8'hb9};
        for (int i = 0; i < 9; i++) begin
            if (i < 6) run(8'h06, 0, 32'h0, 32'h0, 64'h0, q);
            run(ops[i], i[0], 32'h0004_0000, 32'h0, 64'h0, q);
            chk("op", fm_u.last_op, ops[i]);
            chk("len", fm_u.rx.size(),
                (i[0] ? 2 : 1) + (ops[i] inside {8'hdc, 8'he3} ? 4 : 0));
        end
    endtask : t_ops
    task automatic t_dyn_sec;
        run(8'h06, 1, 32'h0, 32'h0, 64'h0, q);
        run(8'he1, 1, 32'h0000_8000, 32'h0, 64'h3c, q);
        chk("one byte", {fm_u.rx.size(), fm_u.rx[6]}, {32'd7, 8'h3c});
        run(8'h06, 0, 32'h0, 32'h0, 64'h0, q);
        run(8'h42, 0, 32'h0, 32'h1, 64'ha5, q);
        chk("secure", {fm_u.rx.size(), fm_u.rx[5]}, {32'd6, 8'ha5});
    endtask : t_dyn_sec
    task automatic t_reads;
        logic [7:0] ops[6] = '{8'h2d, 8'he0, 8'he2, 8'h5d, 8'hd0, 8'h4b};
        logic [7:0] ex[6] = '{8'h00, 8'h3c, 8'hff, 8'h04, 8'h01, 8'ha5};
        for (int i = 0; i < 6; i++) begin
            run(ops[i], i[0], 32'hffff_ffff, 32'h10, 64'h0, q);
            if (i == 0)
                chk("zero addr", {fm_u.rx[1], fm_u.rx[2], fm_u.rx[3], fm_u.rx[4]}, 0);
            apb(0, `OFC_REG_RXLO, 32'h0, q);
            chk("rx byte", q[7:0], ex[i]);
        end
    endtask : t_reads
    task automatic t_rst;
        run(8'h99, 0, 32'h0, 32'h0, 64'h0, q);
        chk("bare reset", q[`OFC_STAT_REFUSED], 1);
        run(8'h66, 0, 32'h0, 32'h0, 64'h0, q);
        run(8'h06, 0, 32'h0, 32'h0, 64'h0, q);
        run(8'h99, 0, 32'h0, 32'h0, 64'h0, q);
        chk("gap reset", q[`OFC_STAT_REFUSED], 1);
        run(8'h66, 1, 32'h0, 32'h0, 64'h0, q);
        chk("armed", q[`OFC_STAT_ARMED], 1);
        run(8'h99, 1, 32'h0, 32'h0, 64'h0, q);
        chk("reset", {q[`OFC_STAT_REFUSED], fm_u.dyn}, {1'b0, 8'hff});
    endtask : t_rst
    task automatic t_pass;
        run(8'he9, 1, 32'hffff_ffff, 32'h0, PW, q);
        chk("pw addr", {fm_u.rx[2], fm_u.rx[3], fm_u.rx[4], fm_u.rx[5]}, 0);
        for (int i = 0; i < 8; i++) chk("pw byte", fm_u.rx[6+i], PW[8*i+:8]);
        run(8'h2d, 0, 32'h0, 32'h10, 64'h0, q);
        apb(0, `OFC_REG_RXLO, 32'h0, q);
        chk("lock bit", q[7:0], 8'h01);
        run(8'he9, 0, 32'h0, 32'h0, ~PW, q);
        chk("locked", fm_u.locked, 1);
        apb(1, `OFC_REG_CTRL, 32'h400, q);
        chk("reset pin", flash_rstn, 0);
        apb(1, `OFC_REG_CTRL, 32'h0, q);
        chk("unlocked", {flash_rstn, fm_u.locked}, 2'b10);
    endtask : t_pass
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (n_fail == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    initial begin
        {pclk, presetn, psel, penable, pwrite, ddr_mode} = '0;
        {paddr, pwdata} = '0;
        {n_fail, compares} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_idle();
        t_erase();
        t_refuse();
        t_ops();
        t_dyn_sec();
        t_reads();
        t_rst();
        t_pass();
        final_report();
    end
endmodule : tb_top

// File: verilog/ofc_cfg.svh
`ifndef OFC_CFG_SVH
`define OFC_CFG_SVH
// register offsets, byte addresses on apb
`define OFC_REG_CTRL 8'h00
`define OFC_REG_ADDR 8'h04
`define OFC_REG_TXLO 8'h08
`define OFC_REG_TXHI 8'h0c
`define OFC_REG_LEN 8'h10
`define OFC_REG_STAT 8'h14
`define OFC_REG_RXLO 8'h18
`define OFC_REG_RXHI 8'h1c
// ctrl fields
`define OFC_CTRL_DDR 8
`define OFC_CTRL_GO 9
`define OFC_CTRL_HWRST 10
// len fields
`define OFC_LEN_TX_LSB 0
`define OFC_LEN_RX_LSB 4
`define OFC_LEN_DM_LSB 8
// status fields
`define OFC_STAT_BUSY 0
`define OFC_STAT_DONE 1
`define OFC_STAT_REFUSED 2
`define OFC_STAT_WEL 3
`define OFC_STAT_ARMED 4
// link timing in pclk cycles per byte slot
`define OFC_DDR_SLOT 4'd6
`define OFC_SDR_SLOT 4'd12
`define OFC_EDGE_A 4'd1
`define OFC_SDR_EDGE_B 4'd7
// opcodes
`define OFC_OP_ERASE_SMALL 8'h21
`define OFC_OP_ERASE_LARGE 8'hdc
`define OFC_OP_ERASE_ALL_A 8'h60
`define OFC_OP_ERASE_ALL_B 8'hc7
`define OFC_OP_CHECK_ERASE 8'hd0
`define OFC_OP_ERASE_COUNT 8'h5d
`define OFC_OP_SUSPEND 8'hb0
`define OFC_OP_RESUME 8'h30
`define OFC_OP_PROG_SECURE 8'h42
`define OFC_OP_READ_SECURE 8'h4b
`define OFC_OP_READ_DYN 8'he0
`define OFC_OP_WRITE_DYN 8'he1
`define OFC_OP_READ_PERS 8'he2
`define OFC_OP_PROG_PERS 8'he3
`define OFC_OP_ERASE_PERS 8'he4
`define OFC_OP_CLR_LOCK 8'h2c
`define OFC_OP_READ_LOCK 8'h2d
`define OFC_OP_PASSWORD 8'he9
`define OFC_OP_RST_ARM 8'h66
`define OFC_OP_RST_EXEC 8'h99
`define OFC_OP_DEEP_SLEEP 8'hb9
`define OFC_OP_WREN 8'h06
`endif

// File: verilog/ofc_host.sv
`timescale 1ns/10ps
// Overview of operation
// - ddr sends opcode on both edges
// - 21 plus four address bytes, msb first
// - dc plus four address bytes
// - 60 or c7, no address
// - d0 plus four address bytes
// - 5d plus address returns erase count
// - b0 suspends, no address
// - 30 resumes, no address
// - 42 plus address then data stream
// - 4b plus address reads secure region
// - e0 plus address reads dynamic byte
// - e1 plus address plus one byte
// - e2 plus address reads persistent byte
// - e3 plus address programs persistent bit
// - e4 sets all persistent bits
// - 2c clears protect lock bit
// - 2d, zero address, lock byte out
// - e9, zero address, password low first
// - 66 must directly precede 99
// - b9 enters deep sleep
// - 06 sets write enable latch
`include "ofc_cfg.svh"
module ofc_host
    import ofc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic flash_ck,
    output logic flash_csn,
    output logic flash_rstn,
    output logic [7:0] dq_o,
    output logic dq_oe,
    input wire logic [7:0] dq_i
);
    ////////////////////////////////////////////////////////////////////////////////
    // opcode decode
    // format of each supported opcode; unknown ones are refused at start
    function automatic ofc_fmt_t cmd_fmt(input logic [7:0] op);
        ofc_fmt_t f;
        f = '0;
        f.known = 1'b1;
        unique case (op)
            `OFC_OP_ERASE_SMALL: begin f.has_addr = 1'b1; f.needs_wel = 1'b1; end
            `OFC_OP_ERASE_LARGE: begin f.has_addr = 1'b1; f.needs_wel = 1'b1; end
            `OFC_OP_ERASE_ALL_A, `OFC_OP_ERASE_ALL_B: f.needs_wel = 1'b1;
            `OFC_OP_CHECK_ERASE: begin f.has_addr = 1'b1; f.reads = 1'b1; end
            `OFC_OP_ERASE_COUNT: begin f.has_addr = 1'b1; f.reads = 1'b1; end
            `OFC_OP_SUSPEND, `OFC_OP_RESUME: f.known = 1'b1;
            `OFC_OP_PROG_SECURE: begin f.has_addr = 1'b1; f.needs_wel = 1'b1; end
            `OFC_OP_READ_SECURE: begin f.has_addr = 1'b1; f.reads = 1'b1; end
            `OFC_OP_READ_DYN, `OFC_OP_READ_PERS: begin f.has_addr = 1'b1; f.reads = 1'b1; end
            `OFC_OP_WRITE_DYN, `OFC_OP_PROG_PERS: begin
                f.has_addr = 1'b1;
                f.needs_wel = 1'b1;
            end
            `OFC_OP_ERASE_PERS, `OFC_OP_CLR_LOCK: f.needs_wel = 1'b1;
            // lock byte read with zero address
            `OFC_OP_READ_LOCK: begin
                f.has_addr = 1'b1;
                f.zero_addr = 1'b1;
                f.reads = 1'b1;
            end
            `OFC_OP_PASSWORD: begin f.has_addr = 1'b1; f.zero_addr = 1'b1; end
            `OFC_OP_RST_ARM, `OFC_OP_RST_EXEC, `OFC_OP_DEEP_SLEEP, `OFC_OP_WREN: f.known = 1'b1;
            default: f.known = 1'b0;
        endcase
        return f;
    endfunction : cmd_fmt

    ////////////////////////////////////////////////////////////////////////////////
    // state and frame geometry
    ofc_regs_t r_ff; // registered state
    ofc_regs_t nxt_r; // next state
    ofc_fmt_t cur_fmt; // format of the frame in flight
    logic [5:0] b_addr; // first address slot
    logic [5:0] b_tx; // first data-out slot
    logic [5:0] b_dm; // first dummy slot
    logic [5:0] b_rx; // first data-in slot
    logic [5:0] b_end; // slot count of the frame
    logic [3:0] n_tx; // data-out bytes
    logic [3:0] slot_len; // pclk cycles per slot
    logic [5:0] nxt_slot; // slot after this one
    logic [5:0] k_rx; // index inside data-in part
    logic apb_wr; // write access phase
    logic [7:0] reg_sel; // decoded offset

    assign cur_fmt = cmd_fmt(r_ff.op);
    // data-out count depends on the opcode, a stream takes the configured length
    always_comb begin
        unique case (r_ff.op)
            `OFC_OP_WRITE_DYN: n_tx = 4'd1;
            `OFC_OP_PASSWORD: n_tx = 4'd8;
            `OFC_OP_PROG_SECURE: n_tx = r_ff.ntx_cfg;
            default: n_tx = 4'd0;
        endcase
    end
    // two opcode slots in ddr, one in sdr
    assign b_addr = r_ff.ddr ? 6'd2 : 6'd1;
    assign b_tx = b_addr + (cur_fmt.has_addr ? 6'd4 : 6'd0);
    assign b_dm = b_tx + {2'b00, n_tx};
    assign b_rx = b_dm + (cur_fmt.reads ? {2'b00, r_ff.ndm_cfg} : 6'd0);
    assign b_end = b_rx + (cur_fmt.reads ? {2'b00, r_ff.nrx_cfg} : 6'd0);
    assign slot_len = r_ff.ddr ? `OFC_DDR_SLOT : `OFC_SDR_SLOT;
    assign nxt_slot = r_ff.slot + 6'd1;
    assign k_rx = r_ff.slot - b_rx;
    assign apb_wr = psel && penable && pwrite;
    assign reg_sel = paddr[7:0];

    // byte driven in a given slot
    function automatic logic [7:0] slot_byte(input logic [5:0] i);
        logic [5:0] k;
        logic [31:0] a_sh;
        logic [63:0] t_sh;
        k = 6'd0;
        a_sh = '0;
        t_sh = '0;
        slot_byte = 8'h00;
        if (i < b_addr) begin
            slot_byte = r_ff.op;
        end else if (i < b_tx) begin
            k = i - b_addr;
            // address goes out most significant byte first
            a_sh = r_ff.addr << {k[1:0], 3'b000};
            slot_byte = cur_fmt.zero_addr ? 8'h00 : a_sh[31:24];
        end else if (i < b_dm) begin
            k = i - b_tx;
            // data and password go out lowest byte first
            t_sh = r_ff.txd >> {k[2:0], 3'b000};
            slot_byte = t_sh[7:0];
        end
    endfunction : slot_byte

    ////////////////////////////////////////////////////////////////////////////////
    // next state: apb first, sequencer after so hardware sets win
    always_comb begin
        ofc_fmt_t sf;
        sf = cmd_fmt(pwdata[7:0]);
        nxt_r = r_ff;
        // pin synchroniser, first stage read only by second
        nxt_r.dq_m = dq_i;
        nxt_r.dq_s = r_ff.dq_m;
        // read data captured in the setup cycle
        if (psel && !penable) begin
            unique case (reg_sel)
                `OFC_REG_CTRL: nxt_r.prdata = {21'h0, ~r_ff.rstn_pin, 1'b0, r_ff.ddr, r_ff.op};
                `OFC_REG_ADDR: nxt_r.prdata = r_ff.addr;
                `OFC_REG_TXLO: nxt_r.prdata = r_ff.txd[31:0];
                `OFC_REG_TXHI: nxt_r.prdata = r_ff.txd[63:32];
                `OFC_REG_LEN: nxt_r.prdata = {20'h0, r_ff.ndm_cfg, r_ff.nrx_cfg, r_ff.ntx_cfg};
                `OFC_REG_STAT: nxt_r.prdata = {27'h0, r_ff.armed, r_ff.wel, r_ff.refused,
                                               r_ff.done, r_ff.st != ofc_idle};
                `OFC_REG_RXLO: nxt_r.prdata = r_ff.rxd[31:0];
                `OFC_REG_RXHI: nxt_r.prdata = r_ff.rxd[63:32];
                default: nxt_r.prdata = 32'h0;
            endcase
        end
        // writes; frame setup registers are frozen while a frame runs
        if (apb_wr) begin
            unique case (reg_sel)
                `OFC_REG_CTRL: begin
                    nxt_r.rstn_pin = ~pwdata[`OFC_CTRL_HWRST];
                    if (r_ff.st == ofc_idle && pwdata[`OFC_CTRL_GO]) begin
                        // host side prerequisites checked before the frame
                        if (!sf.known || (sf.needs_wel && !r_ff.wel) ||
                            (pwdata[7:0] == `OFC_OP_RST_EXEC && !r_ff.armed)) begin
                            nxt_r.refused = 1'b1;
                        end else begin
                            nxt_r.op = pwdata[7:0];
                            nxt_r.ddr = pwdata[`OFC_CTRL_DDR];
                            nxt_r.st = ofc_lead;
                            nxt_r.csn = 1'b0;
                            nxt_r.slot = 6'd0;
                            nxt_r.phase = 4'd0;
                            nxt_r.rxd = 64'h0;
                        end
                    end
                end
                `OFC_REG_ADDR: if (r_ff.st == ofc_idle) nxt_r.addr = pwdata;
                `OFC_REG_TXLO: if (r_ff.st == ofc_idle) nxt_r.txd[31:0] = pwdata;
                `OFC_REG_TXHI: if (r_ff.st == ofc_idle) nxt_r.txd[63:32] = pwdata;
                `OFC_REG_LEN: begin
                    if (r_ff.st == ofc_idle) begin
                        nxt_r.ntx_cfg = pwdata[`OFC_LEN_TX_LSB +: 4];
                        nxt_r.nrx_cfg = pwdata[`OFC_LEN_RX_LSB +: 4];
                        nxt_r.ndm_cfg = pwdata[`OFC_LEN_DM_LSB +: 4];
                    end
                end
                // write one to clear sticky flags
                `OFC_REG_STAT: begin
                    if (pwdata[`OFC_STAT_DONE]) nxt_r.done = 1'b0;
                    if (pwdata[`OFC_STAT_REFUSED]) nxt_r.refused = 1'b0;
                end
                default: nxt_r.op = nxt_r.op;
            endcase
        end
        // link sequencer
        unique case (r_ff.st)
            ofc_idle: nxt_r.ck = 1'b0;
            // first slot presented one cycle after select falls
            ofc_lead: begin
                nxt_r.st = ofc_xfer;
                nxt_r.dq_o = slot_byte(6'd0);
                nxt_r.dq_oe = 1'b1;
            end
            ofc_xfer: begin
                // ddr: one clock edge per slot; sdr: full clock per slot
                if (r_ff.phase == `OFC_EDGE_A ||
                    (!r_ff.ddr && r_ff.phase == `OFC_SDR_EDGE_B)) begin
                    nxt_r.ck = ~r_ff.ck;
                end
                if (r_ff.phase == slot_len - 4'd1) begin
                    if (r_ff.slot >= b_rx) begin
                        nxt_r.rxd[{k_rx[2:0], 3'b000} +: 8] = r_ff.dq_s;
                    end
                    if (nxt_slot >= b_end) begin
                        nxt_r.st = ofc_tail;
                        nxt_r.dq_oe = 1'b0;
                    end else begin
                        nxt_r.slot = nxt_slot;
                        nxt_r.phase = 4'd0;
                        nxt_r.dq_o = slot_byte(nxt_slot);
                        nxt_r.dq_oe = nxt_slot < b_dm;
                    end
                end else begin
                    nxt_r.phase = r_ff.phase + 4'd1;
                end
            end
            ofc_tail: begin
                nxt_r.ck = 1'b0;
                nxt_r.csn = 1'b1;
                nxt_r.dq_o = 8'h00;
                nxt_r.st = ofc_idle;
                nxt_r.done = 1'b1;
                // arming lasts for the very next frame only
                nxt_r.armed = r_ff.op == `OFC_OP_RST_ARM;
                // enable latch shadow; write class frames consume it
                if (r_ff.op == `OFC_OP_WREN) begin
                    nxt_r.wel = 1'b1;
                end else if (cur_fmt.needs_wel || r_ff.op == `OFC_OP_RST_EXEC) begin
                    nxt_r.wel = 1'b0;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff <= '{st: ofc_idle, csn: 1'b1, rstn_pin: 1'b1, default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // outputs: pins from flops, apb handshake combinational
    assign prdata = r_ff.prdata;
    assign pready = psel && penable;
    assign pslverr = pready && (reg_sel > `OFC_REG_RXHI || reg_sel[1:0] != 2'b00);
    assign flash_ck = r_ff.ck;
    assign flash_csn = r_ff.csn;
    assign flash_rstn = r_ff.rstn_pin;
    assign dq_o = r_ff.dq_o;
    assign dq_oe = r_ff.dq_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    // ddr opcode repeated
    chk_ddr_opcode_twice: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == ofc_xfer && r_ff.ddr && r_ff.slot == 6'd1 |-> r_ff.dq_o == r_ff.op)
        else $error("ddr opcode not repeated in second slot");
    chk_addr_msb_first: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == ofc_xfer && cur_fmt.has_addr && !cur_fmt.zero_addr && r_ff.slot == b_addr
        |-> r_ff.dq_o == r_ff.addr[31:24])
        else $error("first address byte is not the top byte");
    chk_zero_addr: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == ofc_xfer && cur_fmt.zero_addr && r_ff.slot >= b_addr && r_ff.slot < b_tx
        |-> r_ff.dq_o == 8'h00 && r_ff.dq_oe)
        else $error("address not zero for zero-address opcode");
    chk_pw_low_first: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == ofc_xfer && r_ff.op == `OFC_OP_PASSWORD && r_ff.slot == b_tx
        |-> r_ff.dq_o == r_ff.txd[7:0])
        else $error("password does not start with its low byte");
    chk_no_addr: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == ofc_xfer && (r_ff.op == `OFC_OP_ERASE_ALL_A || r_ff.op == `OFC_OP_ERASE_ALL_B)
        |-> b_end == b_addr)
        else $error("chip erase frame longer than its opcode");
    // write class needs the enable shadow
    chk_wel_gate: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == ofc_idle ##1 r_ff.st == ofc_lead |-> $past(r_ff.wel) || !cur_fmt.needs_wel)
        else $error("write class frame started without write enable");
    // reset exec only right after arm
    chk_reset_pair: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r_ff.st == ofc_lead) && r_ff.op == `OFC_OP_RST_EXEC |-> $past(r_ff.armed))
        else $error("reset exec sent without arm just before");
    // exactly one data byte, then frame ends
    chk_one_data_byte: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == ofc_xfer && r_ff.op == `OFC_OP_WRITE_DYN |-> b_end == b_tx + 6'd1)
        else $error("dynamic protect write not one data byte");
    // link clock toggles right after phase one, in ddr and sdr alike
    chk_ck_edge: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == ofc_xfer && r_ff.phase == `OFC_EDGE_A |=> r_ff.ck != $past(r_ff.ck))
        else $error("link clock missed its edge");
    // frame ends with select high the cycle after tail
    chk_frame_end: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == ofc_tail |=> r_ff.csn && !r_ff.ck && r_ff.done)
        else $error("frame did not close cleanly");
endmodule : ofc_host

// File: verilog/ofc_pkg.sv
package ofc_pkg;
    // link sequencer states
    typedef enum logic [1:0] {ofc_idle, ofc_lead, ofc_xfer, ofc_tail} ofc_state_t;
    // decoded opcode format
    typedef struct packed {
        logic known;
        logic has_addr;
        logic needs_wel;
        logic zero_addr;
        logic reads;
    } ofc_fmt_t;
    // whole state of the controller
    typedef struct packed {
        ofc_state_t st;
        logic ck;
        logic csn;
        logic [7:0] dq_o;
        logic dq_oe;
        logic rstn_pin;
        logic [3:0] phase;
        logic [5:0] slot;
        logic [7:0] op;
        logic ddr;
        logic [31:0] addr;
        logic [63:0] txd;
        logic [3:0] ntx_cfg;
        logic [3:0] nrx_cfg;
        logic [3:0] ndm_cfg;
        logic [63:0] rxd;
        logic done;
        logic refused;
        logic wel;
        logic armed;
        logic [7:0] dq_m;
        logic [7:0] dq_s;
        logic [31:0] prdata;
    } ofc_regs_t;
endpackage : ofc_pkg
